// *** hdl/sas_pkg.sv ***
// Shared constants and types for the converter sequencer
package sas_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h21;
  localparam logic [ADDR_W-1:0] OFF_RES_HI = 8'h22;
  localparam logic [ADDR_W-1:0] OFF_RES_LO = 8'h23;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_GO_BIT = 6;
  localparam int CH_LSB = 0;
  localparam int CH_W = 4;

  // Mode register fields
  localparam int DIV_LSB = 0;
  localparam int DIV_SEL_W = 3;
  localparam int DIV_CNT_W = 7;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_MAX = 7'h7F;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_TOP = 3'h7;

  // Interrupt bit shared by enable, status and clear
  localparam int IRQ_CONV_BIT = 3;

  // Status register fields
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_SAMPLE_BIT = 6;
  localparam int STAT_IDX_LSB = 0;

  // Result layout: 12-bit code, left-justified over two bytes
  localparam int RES_W = 12;
  localparam int RES_PAD = 4;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] RES_MSB_IDX = 4'hB;
  localparam logic [RES_W-1:0] RES_MSB_ONLY = 12'h800;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  // Channels: eleven pins then the bandgap
  localparam int NUM_CH = 12;
  localparam logic [CH_W-1:0] BANDGAP_CH = 4'hB;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [CH_W-1:0] CH_RST = 4'h0;
  localparam logic [DIV_SEL_W-1:0] DIV_RST = 3'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    SAS_IDLE = 3'b001,
    SAS_SAMPLE = 3'b010,
    SAS_CONVERT = 3'b100
  } sas_state_t;

endpackage : sas_pkg

// *** hdl/sas_clk_div.sv ***
// Conversion clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module sas_clk_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [sas_pkg::DIV_SEL_W-1:0] divSel,
  // Output enable pulse
  output logic tick
);

  typedef struct packed {
    logic [sas_pkg::DIV_CNT_W-1:0] count;
  } sas_div_t;

  sas_div_t div_reg;
  sas_div_t div_next;
  logic [sas_pkg::DIV_CNT_W-1:0] limit;

  // Divide by 2**divSel: 1, 2, 4 ... 128
  assign limit = sas_pkg::DIV_CNT_MAX >> (sas_pkg::DIV_SEL_TOP - divSel);
  assign tick = run && (div_reg.count == limit);

  // Counter held at zero while idle so each window starts with a full period
  always_comb begin
    div_next = div_reg;
    if (!run || tick) begin
      div_next.count = '0;
    end else begin
      div_next.count = div_reg.count + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule : sas_clk_div

// *** hdl/sas_sequencer.sv ***
// Successive-approximation converter sequencer with register port and interrupt
`timescale 1ns/1ps
// What this block does
// - Writing ones to control bits 7 and 6 while already enabled starts; bit 6 reads one once result is ready.
// - Conversion clock is system clock divided by one of eight settings, 1 to 128.
// - Input is sampled for exactly one conversion clock period before conversion.
// - Twelve sources: eleven external pins plus internal bandgap, chosen in control register.
// - Reference is always the supply; bandgap is only ever an input channel.
// - Result is 12-bit code: input over supply times 4096.
// - Result is left-justified over high and low bytes; shift right four.
// - Enable bit in control register; clearing it or writing zero disables.
// - Interrupt enable bit 3 gates completion interrupt; one enables, reset clears.
// - Completion sets interrupt request flag; only a software write or reset clears it.
module sas_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [sas_pkg::ADDR_W-1:0] regAddr,
  input wire logic [sas_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [sas_pkg::DATA_W-1:0] regRdata,
  // Analog front end
  input wire logic compHigh,
  output logic [sas_pkg::CH_W-1:0] channelSel,
  output logic bandgapSel,
  output logic sampleOn,
  output logic [sas_pkg::RES_W-1:0] dacCode,
  output logic refSupply,
  output logic converterOn,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    sas_pkg::sas_state_t state;
    logic enable;
    logic done;
    logic [sas_pkg::CH_W-1:0] channel;
    logic [sas_pkg::DIV_SEL_W-1:0] divSel;
    logic [sas_pkg::RES_W-1:0] result;
    logic [sas_pkg::RES_W-1:0] trial;
    logic [sas_pkg::IDX_W-1:0] bitIdx;
    logic irqEn;
    logic irqFlag;
    logic [sas_pkg::DATA_W-1:0] rdata;
  } sas_regs_t;

  sas_regs_t st_reg;
  sas_regs_t st_next;
  logic conversionClock;
  logic busy;
  logic convFinish;
  logic wrCtrl;
  logic wrMode;
  logic wrIrqEn;
  logic wrIrqClr;
  logic startReq;
  logic divRun;
  logic [sas_pkg::RES_W-1:0] kept;

  assign busy = (st_reg.state != sas_pkg::SAS_IDLE);
  // Restart mid-conversion also clears the divider, so the new window is whole
  assign divRun = busy && !startReq;

  // Conversion clock enable; restarts with each conversion
  sas_clk_div u_clk_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(divRun),
    .divSel(st_reg.divSel),
    .tick(conversionClock)
  );

  // Write decode
  assign wrCtrl = regWrite && (regAddr == sas_pkg::OFF_CTRL);
  assign wrMode = regWrite && (regAddr == sas_pkg::OFF_MODE);
  assign wrIrqEn = regWrite && (regAddr == sas_pkg::OFF_IRQ_EN);
  assign wrIrqClr = regWrite && (regAddr == sas_pkg::OFF_IRQ_CLR);

  // Start only honoured when the converter is already on
  assign startReq = wrCtrl && regWdata[sas_pkg::CTRL_GO_BIT]
                    && regWdata[sas_pkg::CTRL_EN_BIT] && st_reg.enable;

  // Current trial with the tested bit settled by the comparator
  always_comb begin
    kept = st_reg.trial;
    if (!compHigh) begin
      kept[st_reg.bitIdx] = 1'b0;
    end
  end

  assign convFinish = (st_reg.state == sas_pkg::SAS_CONVERT) && conversionClock
                      && (st_reg.bitIdx == '0);

  always_comb begin
    st_next = st_reg;
    st_next.rdata = sas_pkg::DATA_ZERO;

    // Sequencer
    case (st_reg.state)
      sas_pkg::SAS_IDLE: begin
        st_next.state = sas_pkg::SAS_IDLE;
      end
      sas_pkg::SAS_SAMPLE: begin
        // Sample switch closed for one whole conversion clock period
        if (conversionClock) begin
          st_next.state = sas_pkg::SAS_CONVERT;
          st_next.trial = sas_pkg::RES_MSB_ONLY;
          st_next.bitIdx = sas_pkg::RES_MSB_IDX;
        end
      end
      sas_pkg::SAS_CONVERT: begin
        if (conversionClock) begin
          // Binary search against supply-referenced DAC; all ones caps full swing
          st_next.trial = kept;
          if (st_reg.bitIdx == '0) begin
            st_next.result = kept;
            st_next.done = 1'b1;
            st_next.state = sas_pkg::SAS_IDLE;
          end else begin
            st_next.trial[st_reg.bitIdx - 4'h1] = 1'b1;
            st_next.bitIdx = st_reg.bitIdx - 4'h1;
          end
        end
      end
      default: begin
        st_next.state = sas_pkg::SAS_IDLE;
      end
    endcase

    // Control register write; a disable aborts any conversion in flight
    if (wrCtrl) begin
      st_next.enable = regWdata[sas_pkg::CTRL_EN_BIT];
      st_next.channel = regWdata[sas_pkg::CH_LSB +: sas_pkg::CH_W];
      if (!regWdata[sas_pkg::CTRL_EN_BIT]) begin
        st_next.state = sas_pkg::SAS_IDLE;
        st_next.trial = sas_pkg::RES_RST;
        st_next.done = st_reg.done;
        st_next.result = st_reg.result;
      end else if (startReq) begin
        // Restart wins over a conversion still running
        st_next.state = sas_pkg::SAS_SAMPLE;
        st_next.done = 1'b0;
        st_next.result = st_reg.result;
        st_next.trial = sas_pkg::RES_RST;
      end
    end

    if (wrMode) begin
      st_next.divSel = regWdata[sas_pkg::DIV_LSB +: sas_pkg::DIV_SEL_W];
    end

    if (wrIrqEn) begin
      st_next.irqEn = regWdata[sas_pkg::IRQ_CONV_BIT];
    end

    // Flag set beats a clear in the same cycle
    st_next.irqFlag = (st_reg.irqFlag & ~(wrIrqClr & regWdata[sas_pkg::IRQ_CONV_BIT]))
                      | convFinish;

    // Read data valid only in the cycle after the strobe
    if (regRead) begin
      case (regAddr)
        sas_pkg::OFF_CTRL: begin
          st_next.rdata[sas_pkg::CTRL_EN_BIT] = st_reg.enable;
          st_next.rdata[sas_pkg::CTRL_GO_BIT] = st_reg.done;
          st_next.rdata[sas_pkg::CH_LSB +: sas_pkg::CH_W] = st_reg.channel;
        end
        sas_pkg::OFF_MODE: begin
          st_next.rdata[sas_pkg::DIV_LSB +: sas_pkg::DIV_SEL_W] = st_reg.divSel;
        end
        sas_pkg::OFF_RES_HI: begin
          st_next.rdata = st_reg.result[sas_pkg::RES_W-1 -: sas_pkg::DATA_W];
        end
        sas_pkg::OFF_RES_LO: begin
          st_next.rdata[sas_pkg::DATA_W-1 -: sas_pkg::RES_PAD] =
            st_reg.result[sas_pkg::RES_PAD-1:0];
        end
        sas_pkg::OFF_IRQ_EN: begin
          st_next.rdata[sas_pkg::IRQ_CONV_BIT] = st_reg.irqEn;
        end
        sas_pkg::OFF_IRQ_STAT: begin
          st_next.rdata[sas_pkg::IRQ_CONV_BIT] = st_reg.irqFlag;
        end
        sas_pkg::OFF_STATUS: begin
          st_next.rdata[sas_pkg::STAT_BUSY_BIT] = busy;
          st_next.rdata[sas_pkg::STAT_SAMPLE_BIT] = (st_reg.state == sas_pkg::SAS_SAMPLE);
          st_next.rdata[sas_pkg::STAT_IDX_LSB +: sas_pkg::IDX_W] = st_reg.bitIdx;
        end
        default: begin
          st_next.rdata = sas_pkg::DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg.state <= sas_pkg::SAS_IDLE;
      st_reg.enable <= 1'b0;
      st_reg.done <= 1'b0;
      st_reg.channel <= sas_pkg::CH_RST;
      st_reg.divSel <= sas_pkg::DIV_RST;
      st_reg.result <= sas_pkg::RES_RST;
      st_reg.trial <= sas_pkg::RES_RST;
      st_reg.bitIdx <= '0;
      st_reg.irqEn <= 1'b0;
      st_reg.irqFlag <= 1'b0;
      st_reg.rdata <= sas_pkg::DATA_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign regRdata = st_reg.rdata;
  assign channelSel = st_reg.channel;
  assign bandgapSel = (st_reg.channel == sas_pkg::BANDGAP_CH);
  assign sampleOn = (st_reg.state == sas_pkg::SAS_SAMPLE);
  assign dacCode = st_reg.trial;
  // Supply is the only reference; no path routes the bandgap to it
  assign refSupply = 1'b1;
  assign converterOn = st_reg.enable;
  assign irq = st_reg.irqFlag & st_reg.irqEn;

endmodule : sas_sequencer

// *** testbench/sas_monitor.sv ***
// Port checker for the converter sequencer
`timescale 1ns/1ps
module sas_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Front end and interrupt
  input wire logic compHigh,
  input wire logic [3:0] channelSel,
  input wire logic bandgapSel,
  input wire logic sampleOn,
  input wire logic [11:0] dacCode,
  input wire logic refSupply,
  input wire logic converterOn,
  input wire logic irq
);
  logic [2:0] divReg;
  logic [7:0] sCnt;
  wire ctlWr = regWrite && regAddr == sas_pkg::OFF_CTRL;
  wire wEn = regWdata[7];
  // Restart on a start so a restart is not seen as a long window
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      divReg <= 3'h0;
      sCnt <= 8'h00;
    end else begin
      if (regWrite && regAddr == sas_pkg::OFF_MODE) divReg <= regWdata[2:0];
      sCnt <= (sampleOn && !(ctlWr && regWdata[6])) ? sCnt + 8'h01 : 8'h00;
    end
  end
  sequence sStart;
    ctlWr && regWdata[7:6] == 2'b11 && converterOn;
  endsequence
  sequence sIgnore;
    ctlWr && !converterOn;
  endsequence
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ref_supply: assert property (refSupply == 1'b1)
    else $error("reference not supply");
  a_bg_decode: assert property (bandgapSel == (channelSel == sas_pkg::BANDGAP_CH))
    else $error("bandgap select wrong");
  a_enable_follow: assert property (ctlWr |=> converterOn == $past(wEn))
    else $error("enable not taken");
  a_start_sample: assert property (sStart |=> sampleOn)
    else $error("start did not sample");
  a_ignore_start: assert property (sIgnore |=> !sampleOn)
    else $error("start taken while off");
  a_sample_needs_on: assert property (sampleOn |-> converterOn)
    else $error("sampling while off");
  a_window_len: assert property ($fell(sampleOn) && converterOn |-> sCnt == (8'h01 << divReg))
    else $error("sample window length wrong");
  a_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data outside read slot");
endmodule : sas_monitor
bind sas_sequencer sas_monitor mon_u (.sys_clk, .reset, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .compHigh, .channelSel, .bandgapSel, .sampleOn, .dacCode,
  .refSupply, .converterOn, .irq);

// *** testbench/sas_analog_model.sv ***
// Analog sources and comparator seen by the converter
`timescale 1ns/1ps
module sas_analog_model #(
  parameter logic [12:0] BG_LVL = 13'h0666
) (
  // Front end
  input wire logic [3:0] channelSel,
  input wire logic bandgapSel,
  input wire logic sampleOn,
  input wire logic [11:0] dacCode,
  input wire logic refSupply,
  input wire logic converterOn,
  // Comparator
  output logic compHigh
);
  logic [12:0] pin;
  logic [12:0] held;
  // No pulls on the pins; channel 10 sits at the supply
  assign pin = (channelSel == 4'hA) ? 13'h1000 : {1'b0, channelSel, 8'hA5};
  // Level frozen when the sample switch opens
  always_latch begin
    if (sampleOn) held <= bandgapSel ? BG_LVL : pin;
  end
  // No decision without the supply as reference
  assign compHigh = refSupply && converterOn && {1'b0, dacCode} <= held;
endmodule : sas_analog_model

// *** testbench/sar_adc_sequencer_tb_top.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
  localparam logic [12:0] BG_LVL = 13'h0666;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, d;
  logic [3:0] channelSel;
  logic compHigh, bandgapSel, sampleOn, refSupply, converterOn, irq, ien;
  logic [11:0] dacCode, prevRes, expRes;
  logic [7:0] rv [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h04, 8'h05, 8'h7F};
  int error_cnt = 0;
  int n_checks = 0;
  int k;
  always #20 sys_clk = ~sys_clk;
  sas_sequencer dut_u (.sys_clk, .reset, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .compHigh, .channelSel, .bandgapSel, .sampleOn, .dacCode, .refSupply,
    .converterOn, .irq);
  sas_analog_model #(.BG_LVL(BG_LVL)) afe_u (.channelSel, .bandgapSel, .sampleOn,
    .dacCode, .refSupply, .converterOn, .compHigh);
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic reset_vals();
    chk("irq", 12'h000, 12'(irq));
    foreach (rv[i]) begin
      rd(rv[i]);
      chk("reset read", 12'h000, 12'(d));
    end
  endtask : reset_vals
  task automatic conv(logic [3:0] ch);
    logic [2:0] dv;
    dv = ch[2:0];
    expRes = (ch == 4'hA) ? 12'hFFF : (ch == 4'hB) ? BG_LVL[11:0] : {ch, 8'hA5};
    wr(sas_pkg::OFF_MODE, {5'h00, dv});
    wr(sas_pkg::OFF_CTRL, {4'h8, ch});
    wr(sas_pkg::OFF_CTRL, {4'hC, ch});
    #1 k = 0;
    while (sampleOn === 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("sample window", 12'h001 << dv, 12'(k));
    rd(sas_pkg::OFF_RES_HI);
    chk("held result", 12'(prevRes[11:4]), 12'(d));
    rd(sas_pkg::OFF_CTRL);
    chk("done cleared", 12'h000, 12'(d[6]));
    k = 0;
    do begin
      rd(sas_pkg::OFF_CTRL);
      k++;
    end while (d[6] !== 1'b1 && k < 1000);
    if (k >= 1000) begin
      chk("done wait", 12'h001, 12'h000);
      summarize();
    end
    rd(sas_pkg::OFF_RES_HI);
    chk("result high", 12'(expRes[11:4]), 12'(d));
    rd(sas_pkg::OFF_RES_LO);
    chk("result low", {4'h0, expRes[3:0], 4'h0}, 12'(d));
    chk("irq", 12'(ien), 12'(irq));
    rd(sas_pkg::OFF_IRQ_STAT);
    chk("irq flag", 12'h008, 12'(d));
    wr(sas_pkg::OFF_IRQ_CLR, 8'h08);
    #1 chk("irq cleared", 12'h000, 12'(irq));
    prevRes = expRes;
  endtask : conv
  task automatic disabled_start();
    wr(sas_pkg::OFF_CTRL, 8'h00);
    #1 chk("enable", 12'h000, 12'(converterOn));
    wr(sas_pkg::OFF_CTRL, 8'h40);
    repeat (3) begin
      #1 chk("no sample", 12'h000, 12'(sampleOn));
      @(posedge sys_clk);
    end
    // Enable and start in one write from off: only the enable is taken
    wr(sas_pkg::OFF_CTRL, 8'hC0);
    #1 chk("no sample on enable", 12'h000, 12'(sampleOn));
    chk("enable on", 12'h001, 12'(converterOn));
    rd(sas_pkg::OFF_RES_HI);
    chk("kept result", 12'(prevRes[11:4]), 12'(d));
    rd(sas_pkg::OFF_CTRL);
    chk("kept done", 12'h001, 12'(d[6]));
  endtask : disabled_start
  initial begin
    ien = 1'b1;
    prevRes = 12'h000;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    reset_vals();
    wr(sas_pkg::OFF_IRQ_EN, 8'h08);
    // Every divider code and every source, bandgap included
    for (int c = 0; c < 12; c++) conv(4'(c));
    disabled_start();
    ien = 1'b0;
    wr(sas_pkg::OFF_IRQ_EN, 8'h00);
    conv(4'h5);
    summarize();
  end
endmodule : sar_adc_sequencer_tb_top
